// >>> rtl/ner_pkg.sv
// ner_pkg: constants and carrier types for the sector ecc result block
// assumes a 32-bit ahb-lite bus and an ecc engine that reports per sector
package ner_pkg;

  // sector registers, first and count
  localparam int NER_NSECT = 6;
  localparam int NER_FIRST_SECTOR = 6;
  localparam int NER_SECTOR_BYTES = 256;
  localparam int NER_FIRST_BYTE = NER_FIRST_SECTOR * NER_SECTOR_BYTES;

  // byte addresses of the result registers
  localparam logic [31:0] NER_ADDR_SECT6 = 32'h0fffe828;
  localparam logic [31:0] NER_ADDR_SECT7 = 32'h0fffe82c;
  localparam logic [31:0] NER_ADDR_SECT8 = 32'h0fffe830;
  localparam logic [31:0] NER_ADDR_SECT9 = 32'h0fffe834;
  localparam logic [31:0] NER_ADDR_SECT10 = 32'h0fffe838;
  localparam logic [31:0] NER_ADDR_SECT11 = 32'h0fffe83c;
  localparam logic [31:0] NER_ADDR_STEP = 32'h00000004;

  // event status and mask registers
  localparam logic [31:0] NER_ADDR_STATUS = 32'h0fffe860;
  localparam logic [31:0] NER_ADDR_MASK = 32'h0fffe864;

  // result word layout
  localparam int NER_PAR_LSB = 12;
  localparam int NER_PAR_W = 11;
  localparam int NER_BYTE_LSB = 3;
  localparam int NER_BYTE_W = 8;
  localparam int NER_BIT_LSB = 0;
  localparam int NER_BIT_W = 3;

  // status layout: single errors low, multiple errors above
  localparam int NER_EVT_W = 2 * NER_NSECT;
  localparam int NER_MULTI_LSB = NER_NSECT;

  // reset values
  localparam logic [NER_EVT_W-1:0] NER_STATUS_RST = 12'h000;
  localparam logic [NER_EVT_W-1:0] NER_MASK_RST = 12'h000;
  localparam logic [31:0] NER_RDATA_RST = 32'h00000000;

  // ahb encodings
  localparam logic [1:0] NER_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] NER_HTRANS_SEQ = 2'h3;

  // one sector result
  typedef struct packed {
    logic [NER_PAR_W-1:0] parity;
    logic [NER_BYTE_W-1:0] byte_idx;
    logic [NER_BIT_W-1:0] bit_off;
  } ner_sect_s;

  // report from the ecc engine at the end of a sector check
  typedef struct packed {
    logic valid;
    logic [2:0] sector;
    logic single_err;
    logic multi_err;
    logic [NER_PAR_W-1:0] parity;
    logic [NER_BYTE_W-1:0] byte_idx;
    logic [NER_BIT_W-1:0] bit_off;
  } ner_eng_s;

  // ahb reads in the address phase and writes in the data phase, as seen by the register core
  typedef struct packed {
    logic rd;
    logic [31:0] rd_addr;
    logic wr;
    logic [31:0] wr_addr;
  } ner_acc_s;

  // ahb-lite bus inputs
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ner_ahb_in_s;

endpackage

// >>> rtl/ner_ahb_front.sv
// ner_ahb_front: ahb-lite address phase capture for the result block
// assumes zero wait states, so every valid address phase is taken
`timescale 1ns/1ns
module ner_ahb_front (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire ner_pkg::ner_ahb_in_s bus,
  // core side
  output ner_pkg::ner_acc_s acc
);
  import ner_pkg::*;

  typedef struct packed {
    logic wr;
    logic [31:0] wr_addr;
  } ner_front_s;

  ner_front_s st_r;
  ner_front_s st_nxt;
  logic take;

  // a transfer is taken on nonseq or seq with hready high
  assign take = bus.hsel && bus.hready &&
                (bus.htrans == NER_HTRANS_NONSEQ ||
                 bus.htrans == NER_HTRANS_SEQ);

  // write address held into the data phase
  always_comb begin
    st_nxt = st_r;
    if (bus.hready) begin
      st_nxt.wr = take && bus.hwrite;
      st_nxt.wr_addr = bus.haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // reads are served from the address phase itself
  assign acc.rd = take && !bus.hwrite;
  assign acc.rd_addr = bus.haddr;
  assign acc.wr = st_r.wr;
  assign acc.wr_addr = st_r.wr_addr;

endmodule

// >>> rtl/ner_sector_report.sv
// ner_sector_report: ecc result registers for page sectors six to eleven
// assumes an ecc engine that posts one report per checked sector, and an
// ahb-lite master doing single word transfers
`timescale 1ns/1ns
module ner_sector_report (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire ner_pkg::ner_ahb_in_s bus,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // ecc engine reports
  input wire ner_pkg::ner_eng_s eng,
  // interrupt
  output logic irq
);
  import ner_pkg::*;

  typedef struct packed {
    ner_sect_s [NER_NSECT-1:0] res;
    logic [NER_EVT_W-1:0] status;
    logic [NER_EVT_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
  } ner_state_s;

  ner_state_s st_r;
  ner_state_s st_nxt;
  ner_acc_s acc;

  // result word from a sector record, reserved bits zero
  function automatic logic [31:0] pack_result(input ner_sect_s s);
    logic [31:0] w;
    w = 32'h00000000;
    w[NER_PAR_LSB +: NER_PAR_W] = s.parity;
    w[NER_BYTE_LSB +: NER_BYTE_W] = s.byte_idx;
    w[NER_BIT_LSB +: NER_BIT_W] = s.bit_off;
    return w;
  endfunction

  // sector register hit: bit 3 flags a hit, low bits give the index
  function automatic logic [3:0] sect_decode(input logic [31:0] a);
    logic [3:0] r;
    logic [31:0] d;
    r = 4'h0;
    d = a - NER_ADDR_SECT6;
    if (a >= NER_ADDR_SECT6 && a <= NER_ADDR_SECT11 && d[1:0] == 2'h0) begin
      r = {1'b1, d[4:2]};
    end
    return r;
  endfunction

  // bus address phase capture
  ner_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(bus),
    .acc(acc)
  );

  // next state: engine reports, event flags, bus writes, read data
  always_comb begin
    logic [3:0] rdec;
    logic [NER_EVT_W-1:0] set;
    logic [NER_EVT_W-1:0] clr;
    st_nxt = st_r;
    set = '0;
    clr = '0;
    rdec = 4'h0;
    // engine report lands in the addressed sector register
    if (eng.valid && eng.sector < 3'(NER_NSECT)) begin
      st_nxt.res[eng.sector].parity = eng.parity;
      if (eng.single_err || eng.multi_err) begin
        // fields are don't-care on multiple errors, loaded as given
        st_nxt.res[eng.sector].byte_idx = eng.byte_idx;
        st_nxt.res[eng.sector].bit_off = eng.bit_off;
      end else begin
        st_nxt.res[eng.sector].byte_idx = '0;
        st_nxt.res[eng.sector].bit_off = '0;
      end
      if (eng.multi_err) begin
        set[NER_MULTI_LSB + int'(eng.sector)] = 1'b1;
      end else if (eng.single_err) begin
        set[eng.sector] = 1'b1;
      end
    end
    // data phase writes: status is write-one-to-clear, mask plain
    if (acc.wr && acc.wr_addr == NER_ADDR_STATUS) begin
      clr = bus.hwdata[NER_EVT_W-1:0];
    end
    if (acc.wr && acc.wr_addr == NER_ADDR_MASK) begin
      st_nxt.mask = bus.hwdata[NER_EVT_W-1:0];
    end
    // a new event beats a clear in the same cycle
    st_nxt.status = (st_r.status & ~clr) | set;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    // read data from the updated values, unmapped reads zero
    if (acc.rd) begin
      rdec = sect_decode(acc.rd_addr);
      if (rdec[3]) begin
        st_nxt.rdata = pack_result(st_nxt.res[rdec[2:0]]);
      end else if (acc.rd_addr == NER_ADDR_STATUS) begin
        st_nxt.rdata = {20'h00000, st_nxt.status};
      end else if (acc.rd_addr == NER_ADDR_MASK) begin
        st_nxt.rdata = {20'h00000, st_nxt.mask};
      end else begin
        st_nxt.rdata = NER_RDATA_RST;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.res <= '0;
      st_r.status <= NER_STATUS_RST;
      st_r.mask <= NER_MASK_RST;
      st_r.rdata <= NER_RDATA_RST;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus response flops: no wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // outputs straight from flops
  assign hrdata = st_r.rdata;
  assign irq = st_r.irq;

endmodule

// >>> dv/ner_eng_model.sv
// ner_eng_model: ecc engine stand-in posting sector reports
// assumes post is called just after a rising hclk edge
`timescale 1ns/1ns
module ner_eng_model import ner_pkg::*; (
  // clock
  input wire logic hclk,
  // report
  output ner_pkg::ner_eng_s eng
);
  initial eng = '0;
  // one-cycle pulse, fields scrambled once it drops
  task automatic post(input logic [2:0] s, input logic [1:0] k,
                      input logic [21:0] v);
    eng <= {1'b1, s, k, v};
    @(posedge hclk);
    eng <= {1'b0, ~s, ~k, ~v};
  endtask
endmodule

// >>> dv/ner_sector_report_props.sv
// ner_sector_report_props: port checks of the sector result block
// assumes bus.hready is tied to hreadyout
`timescale 1ns/1ns
module ner_sector_report_props import ner_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus and engine
  input wire ner_pkg::ner_ahb_in_s bus,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ner_pkg::ner_eng_s eng,
  input wire logic irq
);
  logic [31:0] exp_r [6];
  logic [31:0] msk_r [6];
  wire [31:0] off = bus.haddr - NER_ADDR_SECT6;
  wire [2:0] sidx = off[4:2];
  wire rany = bus.hsel && bus.hready && bus.htrans[1] && !bus.hwrite;
  wire rres = rany && off < 32'h18;
  // shadow word per sector, multi error hides address fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_r <= '{default: '0};
      msk_r <= '{default: '1};
    end else if (eng.valid && eng.sector < 3'h6) begin
      exp_r[eng.sector] <= {9'h0, eng.parity, 1'b0,
        eng.single_err ? {eng.byte_idx, eng.bit_off} : 11'h0};
      msk_r[eng.sector] <= eng.multi_err ? 32'hfffff800 : '1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_res_s;
    rres;
  endsequence
  sequence rd_any_s;
    rany;
  endsequence
  data_match_a: assert property (rd_res_s |=> ((hrdata ^
    exp_r[$past(sidx)]) & msk_r[$past(sidx)]) == 32'h0)
    else $error("bad word");
  rdata_hold_a: assert property (not rd_any_s |=> $stable(hrdata))
    else $error("read data moved");
  rsvd_zero_a: assert property (rd_res_s |=> hrdata[31:23] == 9'h0
    && !hrdata[11]) else $error("reserved bit set");
  okay_resp_a: assert property (hresp == 1'b0) else $error("not okay");
  ready_hold_a: assert property (hreadyout |=> hreadyout)
    else $error("ready dropped");
endmodule
bind ner_sector_report ner_sector_report_props chk (.hclk(hclk),
  .hresetn(hresetn), .bus(bus), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .eng(eng), .irq(irq));

// >>> dv/tb_nand_page_ecc_sector_report.sv
// tb_nand_page_ecc_sector_report: random and corner checks of the block
// assumes the engine model and bound checker are compiled first
`timescale 1ns/1ns
module tb_nand_page_ecc_sector_report;
  import ner_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [1:0] trans = 2'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rd, hrdata;
  logic [31:0] spare [6];
  logic hreadyout, hresp, irq;
  ner_eng_s eng;
  ner_ahb_in_s bus;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  assign bus = {sel, addr, trans, wr, 3'h2, hreadyout, wdata};
  ner_eng_model eng_m (.hclk(hclk), .eng(eng));
  ner_sector_report dut (.hclk(hclk), .hresetn(hresetn), .bus(bus),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eng(eng),
    .irq(irq));
  initial forever #20 hclk = ~hclk;
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // single ahb transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, d);
    {sel, addr, wr, trans} <= {1'b1, a, w, NER_HTRANS_NONSEQ};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {sel, trans, wdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] exp_w(input logic [21:0] v,
                                        input logic [1:0] k);
    return {9'h0, v[21:11], 1'b0, k[1] ? v[10:0] : 11'h0};
  endfunction
  function automatic logic [31:0] msk(input logic [1:0] k);
    return k[0] ? 32'hfffff800 : 32'hffffffff;
  endfunction
  initial begin
    logic [21:0] v;
    logic [1:0] k;
    void'($urandom(32'ha3a7));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset words, one past the last is unmapped
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, NER_ADDR_SECT6 + 32'(4 * i), 32'h0);
      chk("reset word", 32'h0, rd);
    end
    // all-ones corners, then random single, multi and clean reports
    ahb(1'b1, NER_ADDR_MASK, 32'hfff);
    for (int i = 0; i < 24; i++) begin
      v = i < 6 ? 22'h3fffff : 22'($urandom);
      k = i < 12 ? 2'h2 : 2'($urandom);
      eng_m.post(3'(i % 6), k, v);
      ahb(1'b0, NER_ADDR_SECT6 + 32'(4 * (i % 6)), 32'h0);
      spare[i % 6] = rd;
      chk("word", exp_w(v, k) & msk(k), spare[i % 6] & msk(k));
    end
    #1 chk("irq", 32'h1, {31'h0, irq});
    // status, masking, write-one clear
    ahb(1'b0, NER_ADDR_STATUS, 32'h0);
    chk("status", 32'h3f, {26'h0, rd[5:0]});
    ahb(1'b1, NER_ADDR_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, NER_ADDR_MASK, 32'hfff);
    ahb(1'b1, NER_ADDR_STATUS, 32'hfff);
    ahb(1'b0, NER_ADDR_STATUS, 32'h0);
    chk("status clear", 32'h0, rd);
    repeat (2) @(posedge hclk);
    #1 chk("irq clear", 32'h0, {31'h0, irq});
    // result word ignores writes
    eng_m.post(3'h0, 2'h2, 22'h2a5a5);
    ahb(1'b1, NER_ADDR_SECT6, 32'hffffffff);
    ahb(1'b0, NER_ADDR_SECT6, 32'h0);
    chk("read only", exp_w(22'h2a5a5, 2'h2), rd);
    stop_test();
  end
endmodule
